/* File: shared/lftrtc_pkg.sv */
// ----------------------------------------------------------------------------
// lf tick rtc wakeup timer constants
// ----------------------------------------------------------------------------
package lftrtc_pkg;
   // special function register addresses
   localparam logic [7:0] lftrtc_addr_data_high  = 8'hAB;
   localparam logic [7:0] lftrtc_addr_data_low   = 8'hAC;
   localparam logic [7:0] lftrtc_addr_ind_ctrl   = 8'hAD;
   localparam logic [7:0] lftrtc_addr_tick_div   = 8'hB5;
   localparam logic [7:0] lftrtc_addr_clk_pwr    = 8'hB6;
   localparam logic [7:0] lftrtc_addr_lf_cfg     = 8'hBF;
   // reset values
   localparam logic [7:0] lftrtc_tick_div_reset  = 8'h03;
   localparam logic [5:0] lftrtc_lf_cfg_reset    = 6'h27;
   // indirect control fields
   localparam int         lftrtc_busy_bit        = 4;
   localparam int         lftrtc_write_bit       = 3;
   localparam logic [2:0] lftrtc_idx_high        = 3'h1;
   localparam logic [2:0] lftrtc_idx_low         = 3'h2;
   localparam logic [2:0] lftrtc_idx_disable     = 3'h3;
   // low frequency clock and its divider
   localparam int         lftrtc_clk_hz          = 125_000_000;
   localparam int         lftrtc_lf_hz           = 4_000;
   localparam int         lftrtc_lf_half_cycles  = lftrtc_clk_hz / (2 * lftrtc_lf_hz);
   // rc oscillator model divider (nominal 4 khz too, free running)
   localparam int         lftrtc_rc_half_cycles  = lftrtc_lf_half_cycles;
   // indirect access busy time in core clocks
   localparam int         lftrtc_busy_cycles     = 4;
endpackage : lftrtc_pkg

/* File: design/lftrtc_top.sv */
// Contract
// - lf clock derived from crystal when running
// - rc oscillator sources lf clock otherwise
// - cpu reads lf clock phase
// - tick interval counted in lf periods
// - tick period is divider plus one
// - lf config register six bits reset 27
// - capture input at half rc frequency
// - 24 bit auto reloading down counter
// - disabled at reset, enabled by low write
// - every low write reloads counter
// - disable opcode stops the timer
// - read code selects latch or counter
// - first wakeup within n+1..n+2 ticks
// - each expiry sets wakeup flag
// - expiry forces power down exit unless a nonzero clock write comes in the same cycle
// - pin pulse 1 to 16 ticks
// - nonzero clock write enters power down
// - indirect busy, direction and index fields
// - indirect write indices 1, 2, 3
`timescale 1ns/10ps
`default_nettype none
module lftrtc_top
   import lftrtc_pkg::*;
#(
   parameter int lf_half_cycles = lftrtc_lf_half_cycles, // core clocks per lf half period
   parameter int rc_half_cycles = lftrtc_rc_half_cycles  // core clocks per rc half period
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // special function register port
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // crystal status
   input  wire logic       crystal_running,
   // wakeup and power
   output logic            wakeup_flag_set,
   output logic            power_down,
   input  wire logic       pin_wakeup,
   input  wire logic       watchdog_reset,
   // port pin pulse and timer 2 capture source
   output logic            port0_pin0,
   output logic            port0_pin0_oe,
   input  wire logic       pulse_enable,
   output logic            timer2_ext_input
);
   initial begin
      if (lf_half_cycles < 1 || lf_half_cycles > 65536 ||
          rc_half_cycles < 1 || rc_half_cycles > 65536) begin
         $error("half period counts must lie in 1 to 65536");
      end
   end

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   logic [15:0] xo_cnt, next_xo_cnt;          // crystal derived divider
   logic        xo_ph, next_xo_ph;            // crystal derived lf phase
   logic [15:0] rc_cnt, next_rc_cnt;          // rc oscillator model
   logic        rc_ph, next_rc_ph;            // rc oscillator phase
   logic        rc_half, next_rc_half;        // rc divided by two
   logic        lf_prev, next_lf_prev;        // for lf rising edge
   logic [7:0]  tick_divider, next_tick_divider;
   logic [5:0]  lf_clock_config, next_lf_clock_config;
   logic [7:0]  tick_cnt, next_tick_cnt;      // lf periods within a tick
   logic [7:0]  data_high, next_data_high;
   logic [7:0]  data_low, next_data_low;
   logic [4:0]  ind_ctrl, next_ind_ctrl;
   logic [2:0]  busy_cnt, next_busy_cnt;
   logic [23:0] latch, next_latch;
   logic [23:0] count, next_count;
   logic        enabled, next_enabled;
   logic        reload_pend, next_reload_pend;
   logic [3:0]  pin_pulse_length, next_pin_pulse_length;
   logic [4:0]  pulse_cnt, next_pulse_cnt;    // ticks left in pin pulse
   logic        power_down_q, next_power_down_q;
   logic        flag_q, next_flag_q;
   logic        low_freq_clock;               // selected lf clock
   logic        lf_rise;                      // one core cycle per lf period
   logic        tick;                         // one core cycle per tick
   logic        expire;                       // counter zero reload

   // lf clock select: rc when no crystal
   assign low_freq_clock = crystal_running ? xo_ph : rc_ph;
   assign lf_rise        = low_freq_clock && !lf_prev;
   // tick every divider plus one lf periods
   assign tick           = lf_rise && (tick_cnt == tick_divider);
   // expiry when counter at zero on a tick
   assign expire         = tick && enabled && !reload_pend && (count == 24'h000000);
   assign timer2_ext_input = rc_half; // half rc rate

   // ------------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------------
   // one combinational process; the cpu port and lf logic share state here
   always_comb begin
      next_xo_cnt           = xo_cnt + 16'h0001;
      next_xo_ph            = xo_ph;
      next_rc_cnt           = rc_cnt + 16'h0001;
      next_rc_ph            = rc_ph;
      next_rc_half          = rc_half;
      next_lf_prev          = low_freq_clock;
      next_tick_divider     = tick_divider;
      next_lf_clock_config  = lf_clock_config;
      next_tick_cnt         = tick_cnt;
      next_data_high        = data_high;
      next_data_low         = data_low;
      next_ind_ctrl         = ind_ctrl;
      next_busy_cnt         = busy_cnt;
      next_latch            = latch;
      next_count            = count;
      next_enabled          = enabled;
      next_reload_pend      = reload_pend;
      next_pin_pulse_length = pin_pulse_length;
      next_pulse_cnt        = pulse_cnt;
      next_power_down_q     = power_down_q;
      next_flag_q           = 1'b0;
      // crystal derived lf divider
      if (xo_cnt == 16'(lf_half_cycles - 1)) begin
         next_xo_cnt = 16'h0000;
         next_xo_ph  = !xo_ph;
      end
      // free running rc model, never stops
      if (rc_cnt == 16'(rc_half_cycles - 1)) begin
         next_rc_cnt = 16'h0000;
         next_rc_ph  = !rc_ph;
         if (!rc_ph) begin
            next_rc_half = !rc_half; // toggle on rc rising edge
         end
      end
      // tick divider counts lf periods
      if (lf_rise) begin
         next_tick_cnt = (tick_cnt >= tick_divider) ? 8'h00 : tick_cnt + 8'h01;
      end
      // wakeup counter steps on ticks
      if (tick && enabled) begin
         if (reload_pend) begin
            next_count       = latch; // reload after write
            next_reload_pend = 1'b0;
         end else if (count == 24'h000000) begin
            next_count  = latch;      // auto reload
            next_flag_q = 1'b1;       // wakeup flag
         end else begin
            next_count = count - 24'h000001;
         end
      end
      // pin pulse of length plus one ticks
      if (expire && pulse_enable) begin
         next_pulse_cnt = {1'b0, pin_pulse_length} + 5'h01;
      end else if (tick && pulse_cnt != 5'h00) begin
         next_pulse_cnt = pulse_cnt - 5'h01;
      end
      // busy countdown for indirect transfers
      if (busy_cnt != 3'h0) begin
         next_busy_cnt = busy_cnt - 3'h1;
      end
      // power down exit on expiry or pins or watchdog
      if (expire || pin_wakeup || watchdog_reset) begin
         next_power_down_q = 1'b0;
      end
      // cpu register writes
      if (sfr_wr) begin
         case (sfr_addr)
            lftrtc_addr_tick_div: next_tick_divider = sfr_wdata;
            lftrtc_addr_lf_cfg:   next_lf_clock_config = sfr_wdata[5:0];
            lftrtc_addr_data_high: next_data_high = sfr_wdata;
            lftrtc_addr_data_low:  next_data_low  = sfr_wdata;
            lftrtc_addr_clk_pwr: begin
               // nonzero write starts shutdown
               if (sfr_wdata != 8'h00) begin
                  next_power_down_q = 1'b1;
               end
            end
            lftrtc_addr_ind_ctrl: begin
               next_ind_ctrl = {1'b0, sfr_wdata[3:0]};
               next_busy_cnt = 3'(lftrtc_busy_cycles);
               if (sfr_wdata[lftrtc_write_bit]) begin
                  case (sfr_wdata[2:0])
                     // pulse length and latch high byte
                     lftrtc_idx_high: begin
                        next_pin_pulse_length = data_high[3:0];
                        next_latch[23:16]     = data_low;
                     end
                     // latch low, enable and reload
                     lftrtc_idx_low: begin
                        next_latch[15:0] = {data_high, data_low};
                        next_enabled     = 1'b1;
                        next_reload_pend = 1'b1;
                     end
                     // disable opcode
                     lftrtc_idx_disable: begin
                        next_enabled     = 1'b0;
                        next_reload_pend = 1'b0;
                     end
                     default: begin
                     end
                  endcase
               end else begin
                  // read codes load the data pair
                  case (sfr_wdata[2:0])
                     lftrtc_idx_high: begin
                        next_data_high = count[23:16];
                        next_data_low  = latch[23:16];
                     end
                     lftrtc_idx_low: begin
                        next_data_high = latch[15:8];
                        next_data_low  = latch[7:0];
                     end
                     lftrtc_idx_disable: begin
                        next_data_high = count[15:8];
                        next_data_low  = count[7:0];
                     end
                     default: begin
                        next_data_high = 8'h00;
                        next_data_low  = 8'h00;
                     end
                  endcase
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   // plain register bank with synchronous reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         xo_cnt <= 16'h0000;
         xo_ph <= 1'b0;
         rc_cnt <= 16'h0000;
         rc_ph <= 1'b0;
         rc_half <= 1'b0;
         lf_prev <= 1'b0;
         tick_divider <= lftrtc_tick_div_reset;
         lf_clock_config <= lftrtc_lf_cfg_reset;
         tick_cnt <= 8'h00;
         data_high <= 8'h00;
         data_low <= 8'h00;
         ind_ctrl <= 5'h00;
         busy_cnt <= 3'h0;
         latch <= 24'h000000;
         count <= 24'h000000;
         enabled <= 1'b0; // disabled after reset
         reload_pend <= 1'b0;
         pin_pulse_length <= 4'h0;
         pulse_cnt <= 5'h00;
         power_down_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         xo_cnt <= next_xo_cnt;
         xo_ph <= next_xo_ph;
         rc_cnt <= next_rc_cnt;
         rc_ph <= next_rc_ph;
         rc_half <= next_rc_half;
         lf_prev <= next_lf_prev;
         tick_divider <= next_tick_divider;
         lf_clock_config <= next_lf_clock_config;
         tick_cnt <= next_tick_cnt;
         data_high <= next_data_high;
         data_low <= next_data_low;
         ind_ctrl <= next_ind_ctrl;
         busy_cnt <= next_busy_cnt;
         latch <= next_latch;
         count <= next_count;
         enabled <= next_enabled;
         reload_pend <= next_reload_pend;
         pin_pulse_length <= next_pin_pulse_length;
         pulse_cnt <= next_pulse_cnt;
         power_down_q <= next_power_down_q;
         flag_q <= next_flag_q;
      end
   end

   // ------------------------------------------------------------------------
   // outputs and read mux
   // ------------------------------------------------------------------------
   assign wakeup_flag_set = flag_q;
   assign power_down      = power_down_q;
   assign port0_pin0      = pulse_cnt != 5'h00;
   assign port0_pin0_oe   = pulse_enable;

   // register reads; bit 0 of clock control shows lf phase
   always_comb begin
      sfr_rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            lftrtc_addr_tick_div:  sfr_rdata = tick_divider;
            lftrtc_addr_lf_cfg:    sfr_rdata = {2'b00, lf_clock_config};
            lftrtc_addr_clk_pwr:   sfr_rdata = {7'h00, low_freq_clock};
            lftrtc_addr_data_high: sfr_rdata = data_high;
            lftrtc_addr_data_low:  sfr_rdata = data_low;
            lftrtc_addr_ind_ctrl:  sfr_rdata = {3'b000, busy_cnt != 3'h0, ind_ctrl[3:0]};
            default:               sfr_rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   // a tick must restart the lf period count, else the period drifts
   a_tick_period: assert property (@(posedge core_clk) disable iff (srst)
      tick |=> (tick_cnt == 8'h00))
      else $error("tick did not restart divider count");
   a_reset_disabled: assert property (@(posedge core_clk)
      $fell(srst) |-> !enabled)
      else $error("timer enabled after reset");
   a_low_write_enables: assert property (@(posedge core_clk) disable iff (srst)
      (sfr_wr && sfr_addr == lftrtc_addr_ind_ctrl && sfr_wdata[3:0] == 4'hA)
      |=> enabled && reload_pend)
      else $error("low latch write did not enable and reload");
   a_disable_op: assert property (@(posedge core_clk) disable iff (srst)
      (sfr_wr && sfr_addr == lftrtc_addr_ind_ctrl && sfr_wdata[3:0] == 4'hB)
      |=> !enabled)
      else $error("disable opcode ignored");
   a_expire_reload: assert property (@(posedge core_clk) disable iff (srst)
      (expire && !sfr_wr) |=> count == latch && wakeup_flag_set)
      else $error("expiry did not reload and flag");
   a_pd_exit: assert property (@(posedge core_clk) disable iff (srst)
      (expire && !sfr_wr) |=> !power_down)
      else $error("expiry did not leave power down");
   a_pd_enter: assert property (@(posedge core_clk) disable iff (srst)
      (sfr_wr && sfr_addr == lftrtc_addr_clk_pwr && sfr_wdata != 8'h00
       && !expire && !pin_wakeup && !watchdog_reset) |=> power_down)
      else $error("power down not entered");
   a_pulse_len: assert property (@(posedge core_clk) disable iff (srst)
      (expire && pulse_enable) |=> pulse_cnt == {1'b0, $past(pin_pulse_length)} + 5'h01)
      else $error("pulse length wrong");
   a_busy_flag: assert property (@(posedge core_clk) disable iff (srst)
      (sfr_wr && sfr_addr == lftrtc_addr_ind_ctrl) |=> busy_cnt != 3'h0)
      else $error("busy not raised");
endmodule // lftrtc_top
`default_nettype wire

/* File: sim/test_lftrtc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_lftrtc_top;
   import lftrtc_pkg::*;
   // ----------------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------------
   localparam int lfh = 4;        // shortened lf half period, in core clocks
   localparam int tk  = 8 * lfh;  // default tick: four lf periods
   logic       core_clk, srst, sfr_wr, sfr_rd, crystal_running;
   logic       pin_wakeup, watchdog_reset, pulse_enable;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic       wakeup_flag_set, power_down, port0_pin0, port0_pin0_oe, timer2_ext_input;
   int         bad_count = 0;     // mismatches
   int         checked   = 0;     // comparisons made

   lftrtc_top #(.lf_half_cycles(lfh), .rc_half_cycles(lfh)) u_lftrtc_top (
      .core_clk(core_clk), .srst(srst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .crystal_running(crystal_running), .wakeup_flag_set(wakeup_flag_set),
      .power_down(power_down), .pin_wakeup(pin_wakeup), .watchdog_reset(watchdog_reset),
      .port0_pin0(port0_pin0), .port0_pin0_oe(port0_pin0_oe),
      .pulse_enable(pulse_enable), .timer2_ext_input(timer2_ext_input));

   // free running 125 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic end_sim;
      $display("counts: checked %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // compare a register or pin value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // compare a measured cycle count against a window
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      checked++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("FAIL at %0t: %s took %0d, window %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   // write strobe is dropped a full cycle before the next access may raise it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
      @(negedge core_clk);
   endtask

   // read data is combinational, taken at the rising edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(posedge core_clk);
      d = sfr_rdata;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      @(negedge core_clk);
   endtask

   // poll the busy flag with a bound
   task automatic busy_wait;
      logic [7:0] c;
      for (int i = 0; i < 20; i++) begin
         rd(lftrtc_addr_ind_ctrl, c);
         if (c[lftrtc_busy_bit] === 1'b0) break;
      end
      chk(c[lftrtc_busy_bit], 1'b0, "busy clears");
   endtask

   // indirect write: high byte, low byte, then the control code
   task automatic ind_wr(input logic [2:0] idx, input logic [7:0] hi, input logic [7:0] lo);
      wr(lftrtc_addr_data_high, hi);
      wr(lftrtc_addr_data_low, lo);
      wr(lftrtc_addr_ind_ctrl, {4'h0, 1'b1, idx});
   endtask

   // indirect read: read code, busy seen then cleared, then both data bytes
   task automatic ind_rd(input logic [2:0] idx, output logic [15:0] v);
      logic [7:0] h;
      logic [7:0] l;
      wr(lftrtc_addr_ind_ctrl, {5'h00, idx});
      rd(lftrtc_addr_ind_ctrl, h);
      chk(h, {3'h0, 1'b1, 1'b0, idx}, "ctrl readback busy");
      busy_wait;
      rd(lftrtc_addr_data_high, h);
      rd(lftrtc_addr_data_low, l);
      v = {h, l};
   endtask

   // count falling edges until the wakeup pulse shows, bounded by lim
   task automatic wait_flag(input int lim, output int n);
      n = 0;
      while (wakeup_flag_set !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_regs;
      logic [7:0] d;
      rd(lftrtc_addr_tick_div, d);
      chk(d, 8'h03, "tick divider reset");
      rd(lftrtc_addr_lf_cfg, d);
      chk(d, 8'h27, "lf config reset");
      wr(lftrtc_addr_lf_cfg, 8'h1A);
      rd(lftrtc_addr_lf_cfg, d);
      chk(d, 8'h1A, "lf config written");
      wr(lftrtc_addr_lf_cfg, 8'h27);
      rd(8'h00, d);
      chk(d, 8'h00, "unmapped read");
      $display("test regs done");
   endtask

   // timer stays silent until the first low latch write
   task automatic t_disabled;
      int n;
      wait_flag(10 * tk, n);
      chk_rng(n, 10 * tk, 10 * tk, "no wakeup while disabled");
      $display("test disabled done");
   endtask

   // first wakeup, reload period, readback and disable for divider div
   task automatic t_period(input logic [7:0] div, input logic [7:0] nv);
      int         n;
      int         t;
      logic [15:0] v;
      t = (int'(div) + 1) * 2 * lfh;
      wr(lftrtc_addr_tick_div, div);
      ind_wr(lftrtc_idx_low, 8'h00, nv);
      wait_flag(40 * t, n);
      chk_rng(n, (int'(nv) + 1) * t - 2, (int'(nv) + 2) * t + 2, "first wakeup");
      @(negedge core_clk);
      wait_flag(40 * t, n);
      chk_rng(n + 1, (int'(nv) + 1) * t, (int'(nv) + 1) * t, "reload period");
      ind_rd(lftrtc_idx_low, v);
      chk(v, {8'h00, nv}, "latch low readback");
      ind_rd(lftrtc_idx_disable, v);
      chk_rng(int'(v), 0, int'(nv), "live count");
      ind_wr(lftrtc_idx_disable, 8'hFF, 8'hFF);
      busy_wait;
      wait_flag(3 * (int'(nv) + 2) * t, n);
      chk_rng(n, 3 * (int'(nv) + 2) * t, 3 * (int'(nv) + 2) * t, "silent after disable");
      $display("test period done");
   endtask

   // pin pulse length for lengths 0 and 15, high latch byte set while disabled
   task automatic t_pulse;
      logic [3:0]  lens[2] = '{4'h0, 4'hF};
      logic [15:0] v;
      int          n;
      int          w;
      pulse_enable = 1'b1;
      wr(lftrtc_addr_tick_div, 8'h03);
      foreach (lens[k]) begin
         ind_wr(lftrtc_idx_high, {4'h0, lens[k]}, 8'hA5);
         busy_wait;
         ind_rd(lftrtc_idx_high, v);
         chk(v[7:0], 8'hA5, "latch high readback");
         chk(v[15:8], 8'h00, "counter high readback");
         ind_wr(lftrtc_idx_high, {4'h0, lens[k]}, 8'h00);
         busy_wait;
         ind_wr(lftrtc_idx_low, 8'h00, 8'h14);
         wait_flag(40 * tk, n);
         w = 0;
         for (int i = 0; i < 4 && port0_pin0 !== 1'b1; i++) @(negedge core_clk);
         while (port0_pin0 === 1'b1 && w < 20 * tk) begin
            @(negedge core_clk);
            w++;
         end
         chk_rng(w, (int'(lens[k]) + 1) * tk - 2, (int'(lens[k]) + 1) * tk + 2, "pin pulse");
         chk(port0_pin0_oe, 1'b1, "pin enable");
         ind_wr(lftrtc_idx_disable, 8'h00, 8'h00);
         busy_wait;
      end
      pulse_enable = 1'b0;
      @(negedge core_clk);
      chk(port0_pin0_oe, 1'b0, "pin released");
      $display("test pulse done");
   endtask

   // power down left by timer expiry, pin wakeup and watchdog reset
   task automatic t_power;
      int n;
      for (int k = 0; k < 3; k++) begin
         wr(lftrtc_addr_clk_pwr, 8'h01);
         chk(power_down, 1'b1, "enter power down");
         if (k == 0) begin
            ind_wr(lftrtc_idx_low, 8'h00, 8'h01);
            wait_flag(8 * tk, n);
            // stop the timer so no expiry masks the later pin cases
            ind_wr(lftrtc_idx_disable, 8'h00, 8'h00);
         end else if (k == 1) begin
            pin_wakeup = 1'b1;
         end else begin
            watchdog_reset = 1'b1;
         end
         @(negedge core_clk);
         pin_wakeup     = 1'b0;
         watchdog_reset = 1'b0;
         @(negedge core_clk);
         chk(power_down, 1'b0, "leave power down");
      end
      busy_wait;
      $display("test power done");
   endtask

   // mid-run reset while the timer runs: defaults back, timer disabled
   task automatic t_reset;
      logic [7:0] d;
      int         n;
      wr(lftrtc_addr_tick_div, 8'h01);
      ind_wr(lftrtc_idx_low, 8'h00, 8'h01);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      rd(lftrtc_addr_tick_div, d);
      chk(d, 8'h03, "divider after reset");
      wait_flag(10 * tk, n);
      chk_rng(n, 10 * tk, 10 * tk, "silent after reset");
      $display("test reset done");
   endtask

   // rc source: capture signal half period, lf phase readback, tick still running
   task automatic t_rc;
      logic [7:0] d;
      logic [1:0] seen;
      int         n;
      crystal_running = 1'b0;
      seen            = 2'b00;
      for (int i = 0; i < 16; i++) begin
         rd(lftrtc_addr_clk_pwr, d);
         seen[d[0]] = 1'b1;
      end
      chk(seen, 2'b11, "lf phase toggles");
      @(posedge timer2_ext_input);
      @(negedge core_clk);
      n = 0;
      while (timer2_ext_input !== 1'b0 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk_rng(n, 2 * lfh, 2 * lfh, "capture half period");
      t_period(8'h03, 8'h01);
      crystal_running = 1'b1;
      $display("test rc done");
   endtask

   // ----------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      {sfr_wr, sfr_rd, pin_wakeup, watchdog_reset, pulse_enable} = 5'h00;
      sfr_addr        = 8'h00;
      sfr_wdata       = 8'h00;
      crystal_running = 1'b1;
      srst            = 1'b1;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      t_regs;
      t_disabled;
      t_period(8'h03, 8'h02);
      t_period(8'h01, 8'h05);
      t_pulse;
      t_power;
      t_reset;
      t_rc;
      end_sim;
   end

   // cuts a hang well beyond the expected run of some 5k cycles
   initial begin
      #400000;
      bad_count++;
      $display("FAIL at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule // test_lftrtc_top
`default_nettype wire
